// ==== pin_sync.v ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire mclk,
    input wire srst,
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] pin_sync_q
);

reg [WIDTH-1:0] meta_q;

always @(posedge mclk) begin
    if (srst) begin
        meta_q <= INIT;
        pin_sync_q <= INIT;
    end else begin
        meta_q <= pin;
        pin_sync_q <= meta_q;
    end
end

endmodule

// ==== pin_sync_note_unused.v ====
// no logic of its own; the pin synchroniser is in pin_sync.v
`timescale 1ns/1ps

// ==== tb_top.sv ====
// self-checking bench for the volume stepper
`timescale 1ns/1ps
module tb_top;
    reg mclk = 1'b0;
    reg srst = 1'b1;
    reg ext_sel = 1'b1;
    reg topo = 1'b0;
    reg ret = 1'b1;
    reg shdn_n = 1'b1;
    wire up_n, dn_n, vclk, se_q, muted, s_up, s_dn;
    wire [4:0] idx;
    wire [7:0] db;
    int n_fail = 0;
    int checks_done = 0;
    int n_dn = 0;
    initial forever #2.5 mclk = ~mclk;
    // down pulses, counted at the settled half of the cycle
    always @(negedge mclk)
        if (s_dn === 1'b1)
            n_dn++;
    vol_keys keys (.mclk(mclk), .up_n(up_n), .dn_n(dn_n), .vclk(vclk));
    updown_volume_stepper #(.OSC_PERIOD_CYCLES(20), .OSC_LIMIT_CYCLES(16))
        uut (.mclk(mclk), .srst(srst), .increase_req_n(up_n),
        .decrease_req_n(dn_n), .volume_clk(vclk), .ext_clock_select(ext_sel),
        .output_topology_select(topo), .retention_supply(ret),
        .shutdown_n(shdn_n), .gain_index_q(idx), .gain_db_q(db),
        .single_ended_output_mode_q(se_q), .muted_q(muted),
        .step_up_q(s_up), .step_down_q(s_dn));
    task ck(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // pin to index is three mclk edges, gain_db_q one more
    task settle;
        repeat (8) @(negedge mclk);
    endtask
    task ext(input logic u, input logic d, input int n);
        keys.steps(u, d, n);
        settle;
    endtask
    task t_ext;
        ext(1'b1, 1'b0, 4);
        ck(16'(idx), 16'h0001);
        ck(16'(db), 16'h00D8);
        ck(16'(muted), 16'h0000);
        ext(1'b1, 1'b0, 5);
        ck(16'(idx), 16'h0002);
        ext(1'b1, 1'b0, 3);
        ck(16'(idx), 16'h0003);
        ext(1'b1, 1'b1, 4);
        ck(16'(idx), 16'h0003);
        ext(1'b0, 1'b1, 4);
        ck(16'(idx), 16'h0002);
        ck(16'(n_dn), 16'h0001);
        $display("ext test done");
    endtask
    task t_limits;
        ext(1'b1, 1'b0, 124);
        ck(16'(idx), 16'h001F);
        ck(16'(db), 16'h0014);
        topo = 1'b1;
        settle;
        ck(16'(db), 16'h000E);
        ck(16'(se_q), 16'h0001);
        ext(1'b0, 1'b1, 132);
        ck(16'(idx), 16'h0000);
        ck(16'(db), 16'h00A5);
        ck(16'(muted), 16'h0001);
        topo = 1'b0;
        $display("limits test done");
    endtask
    // internal ticks every 20 mclk, so gaps are ticks times 20
    task t_int;
        int t[7];
        int n;
        int iv[6] = '{800, 400, 240, 160, 80, 80};
        n = 0;
        ext_sel = 1'b0;
        keys.press(1'b1, 1'b0);
        // stop after the seventh step so the index is known afterwards
        for (int i = 0; i < 2000 && n < 7; i++) begin
            @(negedge mclk);
            if (s_up === 1'b1) begin
                t[n] = i;
                n++;
            end
        end
        keys.release_keys;
        settle;
        ck(16'(n), 16'h0007);
        ck(16'(idx), 16'h0007);
        ck(16'(t[0] > 50 && t[0] < 110), 16'h0001);
        for (int k = 0; k < 6; k++)
            ck(16'(t[k+1] - t[k]), 16'(iv[k]));
        $display("internal test done");
    endtask
    task t_ret;
        ext_sel = 1'b1;
        shdn_n = 1'b0;
        ext(1'b0, 1'b1, 4);
        ck(16'(idx), 16'h0007);
        ck(16'(n_dn), 16'h0020);
        shdn_n = 1'b1;
        ret = 1'b0;
        settle;
        ck(16'(idx), 16'h0010);
        ck(16'(db), 16'h00F6);
        ret = 1'b1;
        $display("retention test done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        settle;
        ck(16'(idx), 16'h0000);
        ck(16'(db), 16'h00AB);
        ck(16'(muted), 16'h0001);
        t_ext;
        t_limits;
        t_int;
        t_ret;
        finish_test;
    end
    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
endmodule

// ==== updown_volume_stepper.v ====
// up/down volume stepper with internal or external volume clock
//
// Operation
// [R01] increase request held low raises gain index one 2 dB step, top +20 dB
// [R02] decrease request lowers index by one step, same timing, down to mute
// [R03] index 0 is the -85 dB mute entry and the reset default
// [R04] loss of power without retention resets the setting to mute
// [R05] single-ended mode reports every table entry 6 dB lower
// [R06] internal mode: first step after four sampled-low cycles, then a delay
// [R07] internal hold steps after 4, then 40, 20, 12, 8 further cycles
// [R08] after the fifth step keep stepping every four cycles while held
// [R09] requests sampled on volume clock rising edge, change applied after it
// [R10] external clock selection overrides the internal oscillator
// [R11] external mode: no delay, one step per four rising edges
// [R12] edge counter not cleared between requests; surplus carries forward
// [R13] controller keeps clock low when idle, four pulses per step
// [R14] controller keeps external clock at or below 10 kHz
// [R15] internal oscillator never faster than 500 Hz, 100 Hz nominal
// [R16] setting held through shutdown while retention supply is good
// [R17] retention supply loss loads the -10 dB default setting
// [R18] limits hold the index; both requests low take no step
`timescale 1ns/1ps
`include "volume_stepper_consts.vh"
module updown_volume_stepper #(
    parameter OSC_PERIOD_CYCLES = `OSC_NOM_CYCLES,
    parameter OSC_LIMIT_CYCLES = `OSC_MIN_CYCLES
) (
    input wire mclk,
    input wire srst,
    input wire increase_req_n,
    input wire decrease_req_n,
    input wire volume_clk,
    input wire ext_clock_select,
    input wire output_topology_select,
    input wire retention_supply,
    input wire shutdown_n,
    output reg [`IDX_W-1:0] gain_index_q,
    output reg [`DB_W-1:0] gain_db_q,
    output reg single_ended_output_mode_q,
    output reg muted_q,
    output reg step_up_q,
    output reg step_down_q
);

// the oscillator is never run faster than the rate limit
// both parameters are 32-bit integers, the same width as the counter
localparam [`OSC_CNT_W-1:0] OSC_PERIOD =
    (OSC_PERIOD_CYCLES < OSC_LIMIT_CYCLES) ? OSC_LIMIT_CYCLES
                                           : OSC_PERIOD_CYCLES;

// bridged-mode dB of a table index; single-ended subtracts 6 dB
function [`DB_W-1:0] gain_db;
    input [`IDX_W-1:0] idx;
    input se;
    reg [`DB_W-1:0] base;
    begin
        if (idx == `IDX_MUTE)
            base = `DB_MUTE_BTL; // R03
        else
            base = `DB_BOTTOM_BTL + {2'b00, idx - `IDX_BOTTOM, 1'b0};
        gain_db = se ? base - `DB_SE_OFFSET : base; // R05
    end
endfunction

// cycles to wait at each stage of a continuous hold
function [`HOLD_W-1:0] hold_limit;
    input [`STAGE_W-1:0] stage;
    begin
        case (stage)
            3'h0: hold_limit = `HOLD_T0; // R06
            3'h1: hold_limit = `HOLD_T1; // R07
            3'h2: hold_limit = `HOLD_T2; // R07
            3'h3: hold_limit = `HOLD_T3; // R07
            3'h4: hold_limit = `HOLD_T4; // R07
            default: hold_limit = `HOLD_TN; // R08
        endcase
    end
endfunction

wire [5:0] pins_s;
wire up_n_s;
wire down_n_s;
wire vclk_s;
wire ext_s;
wire se_s;
wire ret_s;

pin_sync #(
    .WIDTH(6),
    .INIT(6'h30)
) u_sync (
    .mclk(mclk),
    .srst(srst),
    .pin({increase_req_n, decrease_req_n, volume_clk, ext_clock_select,
          output_topology_select, retention_supply}),
    .pin_sync_q(pins_s)
);

assign up_n_s = pins_s[5];
assign down_n_s = pins_s[4];
assign vclk_s = pins_s[3];
assign ext_s = pins_s[2];
assign se_s = pins_s[1];
assign ret_s = pins_s[0];

reg vclk_prev_q;
reg ret_prev_q;
reg [`OSC_CNT_W-1:0] osc_cnt_q;
reg osc_tick_q;
reg [`CYC_W-1:0] ext_cnt_q;
reg [`HOLD_W-1:0] hold_cnt_q;
reg [`STAGE_W-1:0] stage_q;
reg ext_prev_q;
reg shutdown_meta_q;
reg shutdown_sync_n_q;

wire ext_edge;
wire tick;
wire up_req;
wire down_req;
wire req;
wire ret_lost;
wire [`HOLD_W-1:0] hold_next;
wire int_step;
wire ext_step;
wire do_step;

// edge finding reads only the second synchroniser stage
assign ext_edge = vclk_s & ~vclk_prev_q;
assign tick = ext_s ? ext_edge : osc_tick_q; // R10 R09
assign up_req = ~up_n_s & down_n_s; // R18
assign down_req = ~down_n_s & up_n_s; // R18
assign req = up_req | down_req;
assign ret_lost = ret_prev_q & ~ret_s;
assign hold_next = hold_cnt_q + 6'h01;
assign int_step = hold_next == hold_limit(stage_q);
assign ext_step = ext_cnt_q == 2'h3; // R11
assign do_step = tick & req & (ext_s ? ext_step : int_step);

// internal oscillator as a divided enable; held still in external mode
always @(posedge mclk) begin
    if (srst) begin
        osc_cnt_q <= 32'h0000_0000;
        osc_tick_q <= 1'b0;
    end else if (ext_s) begin
        osc_cnt_q <= 32'h0000_0000; // R10
        osc_tick_q <= 1'b0;
    end else if (osc_cnt_q >= OSC_PERIOD - 32'h0000_0001) begin
        osc_cnt_q <= 32'h0000_0000; // R15
        osc_tick_q <= 1'b1;
    end else begin
        osc_cnt_q <= osc_cnt_q + 32'h0000_0001;
        osc_tick_q <= 1'b0;
    end
end

always @(posedge mclk) begin
    if (srst) begin
        vclk_prev_q <= 1'b0;
        ret_prev_q <= 1'b0;
        ext_prev_q <= 1'b0;
    end else begin
        vclk_prev_q <= vclk_s;
        ret_prev_q <= ret_s;
        ext_prev_q <= ext_s;
    end
end

// external edge counter: wraps every four requested edges, cleared only by srst
always @(posedge mclk) begin
    if (srst) begin
        ext_cnt_q <= 2'h0;
    end else if (ext_s & tick & req) begin
        ext_cnt_q <= ext_cnt_q + 2'h1; // R11 R12
    end
end

// internal hold schedule; a release restarts from the first stage
always @(posedge mclk) begin
    if (srst) begin
        hold_cnt_q <= 6'h00;
        stage_q <= 3'h0;
    end else if (ext_s | ~req | (ext_prev_q & ~ext_s)) begin
        hold_cnt_q <= 6'h00;
        stage_q <= 3'h0;
    end else if (tick) begin
        if (int_step) begin
            hold_cnt_q <= 6'h00; // R06
            if (stage_q != `STAGE_LAST)
                stage_q <= stage_q + 3'h1; // R07
        end else begin
            hold_cnt_q <= hold_next;
        end
    end
end

// gain index; reset means no retained state, so mute
always @(posedge mclk) begin
    if (srst) begin
        gain_index_q <= `IDX_MUTE; // R03 R04
        step_up_q <= 1'b0;
        step_down_q <= 1'b0;
    end else if (ret_lost) begin
        gain_index_q <= `IDX_RETAIN_DEFAULT; // R17
        step_up_q <= 1'b0;
        step_down_q <= 1'b0;
    end else if (~shutdown_sync_n_q) begin
        step_up_q <= 1'b0; // R16
        step_down_q <= 1'b0;
    end else begin
        step_up_q <= 1'b0;
        step_down_q <= 1'b0;
        if (do_step & up_req & (gain_index_q != `IDX_TOP)) begin
            gain_index_q <= gain_index_q + 5'h01; // R01 R18
            step_up_q <= 1'b1;
        end else if (do_step & down_req & (gain_index_q != `IDX_MUTE)) begin
            gain_index_q <= gain_index_q - 5'h01; // R02 R18
            step_down_q <= 1'b1;
        end
    end
end

// shutdown is a plain level from the same supply domain as the pins
always @(posedge mclk) begin
    if (srst) begin
        shutdown_meta_q <= 1'b1;
        shutdown_sync_n_q <= 1'b1;
    end else begin
        shutdown_meta_q <= shutdown_n;
        shutdown_sync_n_q <= shutdown_meta_q;
    end
end

// reported gain follows the index one cycle later
always @(posedge mclk) begin
    if (srst) begin
        gain_db_q <= `DB_MUTE_BTL;
        single_ended_output_mode_q <= 1'b0;
        muted_q <= 1'b1;
    end else begin
        gain_db_q <= gain_db(gain_index_q, se_s); // R05
        single_ended_output_mode_q <= se_s;
        muted_q <= gain_index_q == `IDX_MUTE;
    end
end

endmodule

// ==== updown_volume_stepper_props.sv ====
// assertion checker for the up/down volume stepper
`timescale 1ns/1ps
module updown_volume_stepper_props (
    input wire mclk,
    input wire srst,
    input wire increase_req_n,
    input wire decrease_req_n,
    input wire volume_clk,
    input wire ext_clock_select,
    input wire retention_supply,
    input wire shutdown_n,
    input wire [4:0] gain_index_q,
    input wire [7:0] gain_db_q,
    input wire single_ended_output_mode_q,
    input wire step_up_q,
    input wire step_down_q
);
    wire [7:0] db_btl = gain_index_q == 5'h00 ? 8'hAB :
        {2'b00, gain_index_q, 1'b0} - 8'h2A;
    wire [7:0] db_exp = db_btl - (single_ended_output_mode_q ? 8'h06 : 8'h00);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_up_inc: assert property (step_up_q |->
        gain_index_q == $past(gain_index_q) + 5'h01) else $error("up step");
    a_down_dec: assert property (step_down_q |->
        gain_index_q == $past(gain_index_q) - 5'h01) else $error("down step");
    a_reset_mute: assert property (disable iff (1'b0) srst |=>
        gain_index_q == 5'h00 && gain_db_q == 8'hAB) else $error("reset");
    a_db_map: assert property ($stable(gain_index_q) |->
        gain_db_q == db_exp)
        else $error("db table");
    a_both_idle: assert property ((!increase_req_n &&
        !decrease_req_n) [*6] |-> !step_up_q && !step_down_q)
        else $error("both low stepped");
    a_limit_hold: assert property (step_up_q || step_down_q |->
        $past(gain_index_q) != (step_up_q ? 5'h1F : 5'h00))
        else $error("past limit");
    a_only_steps: assert property ($changed(gain_index_q) &&
        gain_index_q != 5'h10 |-> step_up_q || step_down_q)
        else $error("stray change");
    a_freeze_off: assert property ((!shutdown_n &&
        retention_supply) [*4] |-> $stable(gain_index_q))
        else $error("shutdown change");
    a_ext_edge: assert property (ext_clock_select &&
        (step_up_q || step_down_q) |-> $past(volume_clk, 2))
        else $error("ext step without edge");
endmodule
bind updown_volume_stepper updown_volume_stepper_props chk (.mclk, .srst,
    .increase_req_n, .decrease_req_n, .volume_clk, .ext_clock_select,
    .retention_supply, .shutdown_n, .gain_index_q, .gain_db_q,
    .single_ended_output_mode_q, .step_up_q, .step_down_q);

// ==== vol_keys.sv ====
// button / host model driving the request pins and volume clock
`timescale 1ns/1ps
module vol_keys (
    input wire mclk,
    output reg up_n = 1'b1,
    output reg dn_n = 1'b1,
    output reg vclk = 1'b0
);
    // pins idle high through their pull-ups
    task press(input logic u, input logic d);
        @(negedge mclk);
        up_n = ~u;
        dn_n = ~d;
    endtask
    task release_keys;
        @(negedge mclk);
        up_n = 1'b1;
        dn_n = 1'b1;
    endtask
    // gated burst, clock low between bursts; far faster than a real host
    // rate cap scaled with the bench clock: only 3 mclk per level matter
    task steps(input logic u, input logic d, input int n);
        press(u, d);
        repeat (n) begin
            #24 vclk = 1'b1;
            #24 vclk = 1'b0;
        end
        #24;
        release_keys;
    endtask
endmodule

// ==== volume_stepper_consts.vh ====
// constants for the up/down volume stepper
`ifndef VOLUME_STEPPER_CONSTS_VH
`define VOLUME_STEPPER_CONSTS_VH

// system clock
`define MCLK_HZ 200000000

// gain table indices: 0 is mute, 1 is the lowest audible step, 31 the top
`define IDX_W 5
`define IDX_MUTE 5'h00
`define IDX_BOTTOM 5'h01
`define IDX_TOP 5'h1F
`define IDX_RETAIN_DEFAULT 5'h10

// gain in dB, bridged mode
`define DB_W 8
`define DB_BOTTOM_BTL 8'hD8
`define DB_MUTE_BTL 8'hAB
`define DB_STEP 8'h02
`define DB_SE_OFFSET 8'h06

// edges of the volume clock needed for one step
`define STEP_TICKS 4
`define CYC_W 2

// hold schedule in volume clock cycles, internal mode
`define HOLD_W 6
`define HOLD_T0 6'h04
`define HOLD_T1 6'h28
`define HOLD_T2 6'h14
`define HOLD_T3 6'h0C
`define HOLD_T4 6'h08
`define HOLD_TN 6'h04
`define STAGE_W 3
`define STAGE_LAST 3'h5

// internal oscillator: recommended and fastest rates
`define OSC_NOM_HZ 100
`define OSC_MAX_HZ 500
`define OSC_NOM_CYCLES (`MCLK_HZ / `OSC_NOM_HZ)
`define OSC_MIN_CYCLES (`MCLK_HZ / `OSC_MAX_HZ)
`define OSC_CNT_W 32

`endif
